// ==== ccrd_core_clock_ratio_decode.v ====
/*
 * core clock ratio decoder: turns the four-bit board strap into a
 * bus-to-core multiplier, a core-to-vco multiplier and a mode
 * (pll, pll bypass, clock off), plus the data receiver enable.
 * assumes the strap and bus_reference_clock sample are synchronous
 * to sys_clk and the strap holds steady while running.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ccrd_regs.vh"

// What this block does
// - decode ten pll strap codes into core multipliers
// - vco twice core, code 0101 four times
// - code 0011 bypasses pll, core from bus clock
// - code 1111 stops all internal clocking
// - data receivers follow the read flag, one cycle late
module ccrd_core_clock_ratio_decode (
	input  wire       sys_clk,             // 200 mhz system clock
	input  wire       sys_rst,             // synchronous reset, active high
	input  wire [3:0] ratio_sel,           // board strap, bit 3 is the first strap pin
	input  wire       bus_reference_clock, // sampled bus clock level
	input  wire       read_active,         // a read data transfer is in progress
	output reg  [3:0] core_mult_half_q,    // bus-to-core multiplier times two
	output reg  [2:0] vco_mult_q,          // core-to-vco multiplier
	output reg  [1:0] clk_mode_q,          // off, pll, bypass or reserved
	output reg        pll_enable_q,        // pll running
	output reg        core_clk_q,          // bypass core clock follows bus clock
	output reg        core_clk_run_q,      // any internal clocking present
	output reg        code_reserved_q,     // strap holds an unlisted code
	output reg        data_rcv_en_q        // data bus input receivers on
);

	// next values of the registered outputs
	reg [3:0] core_mult_half_d; // bus-to-core multiplier times two
	reg [2:0] vco_mult_d;       // core-to-vco multiplier
	reg [1:0] clk_mode_d;       // off, pll, bypass or reserved
	reg       pll_enable_d;     // pll to run
	reg       core_clk_d;       // bypass core clock level
	reg       core_clk_run_d;   // some internal clocking present
	reg       code_reserved_d;  // unlisted strap code
	reg       data_rcv_en_d;    // data receivers to be on

	// strap code to bus-to-core multiplier, held in half steps
	always @* begin
		core_mult_half_d = `CCRD_HALF_NONE;
		case (ratio_sel)
		`CCRD_CODE_X2: begin
			core_mult_half_d = `CCRD_HALF_2;
		end
		`CCRD_CODE_X2_VCO4: begin
			core_mult_half_d = `CCRD_HALF_2;
		end
		`CCRD_CODE_X2P5: begin
			core_mult_half_d = `CCRD_HALF_2P5;
		end
		`CCRD_CODE_X3: begin
			core_mult_half_d = `CCRD_HALF_3;
		end
		`CCRD_CODE_X3P5: begin
			core_mult_half_d = `CCRD_HALF_3P5;
		end
		`CCRD_CODE_X4: begin
			core_mult_half_d = `CCRD_HALF_4;
		end
		`CCRD_CODE_X4P5: begin
			core_mult_half_d = `CCRD_HALF_4P5;
		end
		`CCRD_CODE_X5: begin
			core_mult_half_d = `CCRD_HALF_5;
		end
		`CCRD_CODE_X5P5: begin
			core_mult_half_d = `CCRD_HALF_5P5;
		end
		`CCRD_CODE_X6: begin
			core_mult_half_d = `CCRD_HALF_6;
		end
		`CCRD_CODE_BYPASS: begin
			core_mult_half_d = `CCRD_HALF_1;    // 1:1 bus
		end
		`CCRD_CODE_OFF: begin
			core_mult_half_d = `CCRD_HALF_NONE; // no core clock
		end
		default: begin
			core_mult_half_d = `CCRD_HALF_NONE; // unlisted codes
		end
		endcase
	end

	// core-to-vco multiplier; only the pll codes run a vco
	always @* begin
		vco_mult_d = `CCRD_VCO_NONE;
		case (ratio_sel)
		`CCRD_CODE_X2: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X2_VCO4: begin
			vco_mult_d = `CCRD_VCO_X4;
		end
		`CCRD_CODE_X2P5: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X3: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X3P5: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X4: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X4P5: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X5: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X5P5: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_X6: begin
			vco_mult_d = `CCRD_VCO_X2;
		end
		`CCRD_CODE_BYPASS: begin
			vco_mult_d = `CCRD_VCO_NONE;        // pll off
		end
		`CCRD_CODE_OFF: begin
			vco_mult_d = `CCRD_VCO_NONE;
		end
		default: begin
			vco_mult_d = `CCRD_VCO_NONE;        // unlisted codes
		end
		endcase
	end

	// strap code to operating mode
	always @* begin
		clk_mode_d = `CCRD_MODE_RSVD;
		case (ratio_sel)
		`CCRD_CODE_X2:      clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X2_VCO4: clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X2P5:    clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X3:      clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X3P5:    clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X4:      clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X4P5:    clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X5:      clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X5P5:    clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_X6:      clk_mode_d = `CCRD_MODE_PLL;
		`CCRD_CODE_BYPASS:  clk_mode_d = `CCRD_MODE_BYPASS;
		`CCRD_CODE_OFF:     clk_mode_d = `CCRD_MODE_OFF;
		default:            clk_mode_d = `CCRD_MODE_RSVD;
		endcase
	end

	// flags derived from the decoded mode; receiver enable from the read flag
	always @* begin
		// the pll runs only for a listed multiplier code
		pll_enable_d    = (clk_mode_d == `CCRD_MODE_PLL);
		// bypass passes the bus clock through; every other mode holds low
		core_clk_d      = (clk_mode_d == `CCRD_MODE_BYPASS) &
			bus_reference_clock;
		// clock off and reserved codes leave the core unclocked
		core_clk_run_d  = (clk_mode_d == `CCRD_MODE_PLL) |
			(clk_mode_d == `CCRD_MODE_BYPASS);
		code_reserved_d = (clk_mode_d == `CCRD_MODE_RSVD);
		// receivers follow the read transfer, off between reads
		data_rcv_en_d   = read_active;
	end

	// bus-to-core multiplier register
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			core_mult_half_q <= `CCRD_RST_MULT;
		end else begin
			core_mult_half_q <= core_mult_half_d;
		end
	end

	// core-to-vco multiplier register
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			vco_mult_q <= `CCRD_RST_VCO;
		end else begin
			vco_mult_q <= vco_mult_d;
		end
	end

	// operating mode register, off while in reset
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			clk_mode_q <= `CCRD_RST_MODE;
		end else begin
			clk_mode_q <= clk_mode_d;
		end
	end

	// pll enable register
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			pll_enable_q <= `CCRD_RST_FLAG;
		end else begin
			pll_enable_q <= pll_enable_d;
		end
	end

	// bypass core clock, one cycle behind the bus clock sample
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			core_clk_q <= `CCRD_RST_FLAG;
		end else begin
			core_clk_q <= core_clk_d;
		end
	end

	// internal clocking present
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			core_clk_run_q <= `CCRD_RST_FLAG;
		end else begin
			core_clk_run_q <= core_clk_run_d;
		end
	end

	// unlisted strap code report
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			code_reserved_q <= `CCRD_RST_FLAG;
		end else begin
			code_reserved_q <= code_reserved_d;
		end
	end

	// data receiver enable, one cycle behind the read flag
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			data_rcv_en_q <= `CCRD_RST_FLAG;
		end else begin
			data_rcv_en_q <= data_rcv_en_d;
		end
	end

endmodule // ccrd_core_clock_ratio_decode
`default_nettype wire

// ==== ccrd_regs.vh ====
/*
 * constants of the core clock ratio decoder: strap codes, multiplier
 * encodings and reset values. assumes inclusion by bare name only.
 */
`ifndef CCRD_REGS_VH
`define CCRD_REGS_VH

// four-bit ratio strap codes
`define CCRD_CODE_X2       4'h4
`define CCRD_CODE_X2_VCO4  4'h5
`define CCRD_CODE_X2P5     4'h6
`define CCRD_CODE_X3       4'h8
`define CCRD_CODE_X3P5     4'hE
`define CCRD_CODE_X4       4'hA
`define CCRD_CODE_X4P5     4'h7
`define CCRD_CODE_X5       4'hB
`define CCRD_CODE_X5P5     4'h9
`define CCRD_CODE_X6       4'hD
`define CCRD_CODE_BYPASS   4'h3
`define CCRD_CODE_OFF      4'hF

// multipliers held in half steps (value = multiplier * 2)
`define CCRD_HALF_1        4'h2
`define CCRD_HALF_2        4'h4
`define CCRD_HALF_2P5      4'h5
`define CCRD_HALF_3        4'h6
`define CCRD_HALF_3P5      4'h7
`define CCRD_HALF_4        4'h8
`define CCRD_HALF_4P5      4'h9
`define CCRD_HALF_5        4'hA
`define CCRD_HALF_5P5      4'hB
`define CCRD_HALF_6        4'hC
`define CCRD_HALF_NONE     4'h0

// core-to-vco multipliers
`define CCRD_VCO_NONE      3'h0
`define CCRD_VCO_X2        3'h2
`define CCRD_VCO_X4        3'h4

// reset values: clocks stopped until the strap is decoded
`define CCRD_RST_MODE      2'h0
`define CCRD_RST_MULT      4'h0
`define CCRD_RST_VCO       3'h0
`define CCRD_RST_FLAG      1'b0

// operating modes
`define CCRD_MODE_OFF      2'h0
`define CCRD_MODE_PLL      2'h1
`define CCRD_MODE_BYPASS   2'h2
`define CCRD_MODE_RSVD     2'h3

`endif

// ==== ccrd_sva.sv ====
/* ccrd checks at the ports; assumes bind into the decoder */
`timescale 1ns/10ps
`default_nettype none
module ccrd_sva (
	input wire       sys_clk,             // decoder clock
	input wire       sys_rst,             // synchronous reset, active high
	input wire       bus_reference_clock, // sampled bus clock level
	input wire       read_active,         // read transfer in progress
	input wire [3:0] ratio_sel,           // board strap
	input wire [3:0] core_mult_half_q,    // multiplier times two
	input wire [2:0] vco_mult_q,          // core-to-vco multiplier
	input wire       pll_enable_q,        // pll running
	input wire       core_clk_q,          // bypass core clock
	input wire       core_clk_run_q,      // internal clocking present
	input wire       code_reserved_q,     // unlisted strap code
	input wire       data_rcv_en_q        // data receivers on
);
	reg rst_prev_q = 1'b1; // masks the first edge after reset
	always @(posedge sys_clk) rst_prev_q <= sys_rst;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_mult_six: assert property (!rst_prev_q && $past(ratio_sel) == 4'hD
		|-> core_mult_half_q == 4'hC) else $error("six mult");
	a_vco_quad: assert property (!rst_prev_q && $past(ratio_sel) == 4'h5
		|-> vco_mult_q == 3'h4 && core_mult_half_q == 4'h4) else $error("vco quad");
	a_bypass_follow: assert property (!rst_prev_q && $past(ratio_sel) == 4'h3
		|-> core_clk_q == $past(bus_reference_clock) && !pll_enable_q) else $error("bypass");
	a_clock_off: assert property (!rst_prev_q && $past(ratio_sel) == 4'hF
		|-> !core_clk_run_q && !core_clk_q) else $error("clock off");
	a_rcv_gate: assert property (!rst_prev_q
		|-> data_rcv_en_q == $past(read_active)) else $error("receivers");
	a_code_reserved: assert property (!rst_prev_q && $past(ratio_sel) == 4'h0
		|-> code_reserved_q && !core_clk_run_q && vco_mult_q == 3'h0) else $error("reserved");
endmodule // ccrd_sva
`default_nettype wire

// ==== ccrd_strap.sv ====
/* board strap model; assumes the bench names the code */
`timescale 1ns/10ps
`default_nettype none
module ccrd_strap (input wire sys_clk, input wire [3:0] code_sel,
	output logic [3:0] ratio_sel, output logic bus_reference_clock);
	initial ratio_sel = 4'hF;
	initial bus_reference_clock = 1'b0;
	// bench code, listed or not, held between changes; bus clock runs free
	always @(negedge sys_clk) begin
		ratio_sel <= code_sel;
		bus_reference_clock <= ~bus_reference_clock;
	end
endmodule // ccrd_strap
`default_nettype wire

// ==== ccrd_core_clock_ratio_decode_tb.sv ====
/* decoder bench; assumes ccrd_strap drives the strap pins */
`timescale 1ns/10ps
`default_nettype none
module ccrd_core_clock_ratio_decode_tb;
	logic sys_clk = 1'b0, sys_rst = 1'b1, read_active = 1'b0, bus_clk, pll, cclk, run, rcv, rsv;
	logic [3:0] code_sel = 4'hF, ratio_sel, mult;
	logic [2:0] vco;
	logic [1:0] mode;
	int miscompares = 0, compares = 0;
	always #2.5 sys_clk = ~sys_clk; // 200 mhz
	ccrd_strap u_strap (.sys_clk(sys_clk), .code_sel(code_sel), .ratio_sel(ratio_sel),
		.bus_reference_clock(bus_clk));
	ccrd_core_clock_ratio_decode u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.ratio_sel(ratio_sel), .bus_reference_clock(bus_clk), .read_active(read_active),
		.core_mult_half_q(mult), .vco_mult_q(vco), .clk_mode_q(mode), .pll_enable_q(pll),
		.core_clk_q(cclk), .core_clk_run_q(run), .code_reserved_q(rsv), .data_rcv_en_q(rcv));
	task automatic check(input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic strap(input logic [3:0] c);
		code_sel <= c;
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic t_pll;
		logic [39:0] codes = 40'h46_8EA7_B9D5; // listed pll codes, first in the top bits
		for (int i = 0; i < 10; i++) begin
			strap(codes[39 - 4 * i -: 4]);
			check(mult, i < 9 ? 8'(i + 4) : 8'h04);
			check(vco, i < 9 ? 8'h02 : 8'h04);
			check({rsv, pll, run, mode}, 8'h0D);
		end
	endtask
	task automatic t_clk(input logic [3:0] c, input logic [7:0] e, r);
		logic b;
		strap(c);
		check({pll, run, mode, mult}, e);
		check({rsv, vco}, r);
		// bus clock level taken where the decoder samples it
		repeat (4) begin
			@(posedge sys_clk);
			b = bus_clk;
			@(negedge sys_clk);
			check(cclk, c == 4'h3 ? b : 1'b0);
		end
	endtask
	task automatic t_rcv;
		read_active <= 1'b1;
		@(negedge sys_clk);
		check(rcv, 8'h01);
		read_active <= 1'b0;
		@(negedge sys_clk);
		check(rcv, 8'h00);
	endtask
	task automatic conclude;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// reset, then the scenarios
	initial begin
		repeat (5) @(negedge sys_clk);
		sys_rst <= 1'b0;
		t_pll;
		t_clk(4'h3, 8'h62, 8'h00);
		t_clk(4'hF, 8'h00, 8'h00);
		// deliberate misuse: an unlisted strap is reported, no clocking
		t_clk(4'h0, 8'h30, 8'h08);
		t_rcv;
		conclude;
	end
	// watchdog, well past the expected run
	initial begin
		#2000;
		miscompares++;
		conclude;
	end
endmodule // ccrd_core_clock_ratio_decode_tb
bind ccrd_core_clock_ratio_decode ccrd_sva u_sva (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.bus_reference_clock(bus_reference_clock),
	.read_active(read_active),
	.ratio_sel(ratio_sel),
	.core_mult_half_q(core_mult_half_q),
	.vco_mult_q(vco_mult_q),
	.pll_enable_q(pll_enable_q),
	.core_clk_q(core_clk_q),
	.core_clk_run_q(core_clk_run_q),
	.code_reserved_q(code_reserved_q),
	.data_rcv_en_q(data_rcv_en_q)
);
`default_nettype wire
